// >>> src/srdr_pkg.sv
//------------------------------------------------------------
// Function
// - four-bit channel 7 slot select, binary coded, slot 7 after reset
// - channel 7 drive bit: clear floats its slot, set drives it; set at reset
// - two-bit serial data pad drive level, codes 2.5/5/10/15 mA, default 2
// - two-bit second mic clock pad drive level, same code map, default 2
// - two-bit first mic clock pad drive level, same code map, default 2
// - full soft reset bit holds device and registers at reset; write-only, 0
// - partial soft reset software_reset_control operating logic, keeps registers; write-only, 0
//------------------------------------------------------------
package srdr_pkg;
	// register offsets on the control port
	localparam logic [7:0] ADDR_CH7_ROUTE = 8'h10;
	localparam logic [7:0] ADDR_PAD_DRIVE = 8'h11;
	localparam logic [7:0] ADDR_SW_RESET = 8'h12;
	// field positions
	localparam int CH7_SLOT_LSB = 4;
	localparam int CH7_DRV_BIT = 0;
	localparam int SERIAL_DS_LSB = 4;
	localparam int CLK_B_DS_LSB = 2;
	localparam int CLK_A_DS_LSB = 0;
	localparam int FULL_RST_BIT = 1;
	localparam int PART_RST_BIT = 0;
	// reset values
	localparam logic [7:0] CH7_ROUTE_RESET = 8'h71;
	localparam logic [7:0] PAD_DRIVE_RESET = 8'h2A;
	localparam logic [7:0] SW_RESET_RESET = 8'h00;
	localparam logic [3:0] CH7_SLOT_RESET = 4'h7;
	localparam logic CH7_DRV_RESET = 1'b1;
	localparam logic [1:0] DS_RESET = 2'h2;
	// drive level codes (2.5, 5, 10, 15 mA)
	typedef enum logic [1:0] {
		SRDR_DS_2P5MA = 2'b00,
		SRDR_DS_5MA = 2'b01,
		SRDR_DS_10MA = 2'b10,
		SRDR_DS_15MA = 2'b11
	} srdr_ds_t;
endpackage

// >>> src/srdr_slot_if.sv
`timescale 1ns/100ps
// slot routing signals between register bank and pin driver
interface srdr_slot_if;
	logic [3:0] slot_select;
	logic drive_enable;
	logic run;
	logic [3:0] slot_index;
	logic slot_data;
	modport ctrl (output slot_select, output drive_enable, output run,
		output slot_index, output slot_data);
	modport drv (input slot_select, input drive_enable, input run,
		input slot_index, input slot_data);
endinterface

// >>> src/srdr_slot_drive.sv
`timescale 1ns/100ps
module srdr_slot_drive (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// routing from register bank
	srdr_slot_if.drv slot,
	// serial data pin
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe
);
	typedef struct packed {
		logic pin_out;
		logic pin_oe;
	} srdr_drv_state_t;

	srdr_drv_state_t st_r;
	srdr_drv_state_t st_nxt;

	// drive only in the chosen slot; floats otherwise so other talkers share the line
	always_comb begin
		st_nxt = st_r;
		st_nxt.pin_oe = slot.run && slot.drive_enable
			&& (slot.slot_index == slot.slot_select);
		st_nxt.pin_out = st_nxt.pin_oe ? slot.slot_data : 1'b0;
	end

	// one register stage aligns enable and data
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign serial_out_pin_o = st_r.pin_out;
	assign serial_out_pin_oe = st_r.pin_oe;
endmodule // srdr_slot_drive

// >>> src/srdr_regs.sv
`timescale 1ns/100ps
module srdr_regs (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// control port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// serializer slot timing
	input wire logic [3:0] slot_index,
	input wire logic slot_data,
	// serial data pin
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe,
	// pad drive levels
	output logic [1:0] serial_out_drive_level,
	output logic [1:0] mic_clock_b_drive_level,
	output logic [1:0] mic_clock_a_drive_level,
	// operating logic reset
	output logic core_reset
);
	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	typedef struct packed {
		logic [3:0] ch7_slot_select;
		logic ch7_drive_enable;
		logic [1:0] serial_ds;
		logic [1:0] clk_b_ds;
		logic [1:0] clk_a_ds;
		logic full_reset;
		logic part_reset;
		logic [7:0] rdata;
		logic rvalid;
	} srdr_reg_state_t;

	srdr_reg_state_t st_r;
	srdr_reg_state_t st_nxt;
	srdr_slot_if slot_bus ();

	//------------------------------------------------------------
	// address decode
	//------------------------------------------------------------
	// one hit line per mapped offset and direction, except reads of the write-only reset register
	logic route_wr_hit;
	logic route_rd_hit;
	logic pad_wr_hit;
	logic pad_rd_hit;
	logic swrst_wr_hit;
	// settings are held at defaults while the full soft reset bit is high
	logic settings_held;
	// read words assembled with reserved bits at zero
	logic [7:0] route_word;
	logic [7:0] pad_word;

	// decoded from the level address, qualified by the strobes
	assign route_wr_hit = reg_write && (reg_addr == srdr_pkg::ADDR_CH7_ROUTE);
	assign route_rd_hit = reg_read && (reg_addr == srdr_pkg::ADDR_CH7_ROUTE);
	assign pad_wr_hit = reg_write && (reg_addr == srdr_pkg::ADDR_PAD_DRIVE);
	assign pad_rd_hit = reg_read && (reg_addr == srdr_pkg::ADDR_PAD_DRIVE);
	assign swrst_wr_hit = reg_write && (reg_addr == srdr_pkg::ADDR_SW_RESET);
	assign settings_held = st_r.full_reset;

	//------------------------------------------------------------
	// read word assembly
	//------------------------------------------------------------
	// routing word: slot in the upper nibble, drive bit at the bottom
	always_comb begin
		route_word = 8'h00;
		route_word[srdr_pkg::CH7_SLOT_LSB +: 4] = st_r.ch7_slot_select;
		route_word[srdr_pkg::CH7_DRV_BIT] = st_r.ch7_drive_enable;
	end

	// pad word: three two-bit codes, top two bits reserved
	always_comb begin
		pad_word = 8'h00;
		pad_word[srdr_pkg::SERIAL_DS_LSB +: 2] = st_r.serial_ds;
		pad_word[srdr_pkg::CLK_B_DS_LSB +: 2] = st_r.clk_b_ds;
		pad_word[srdr_pkg::CLK_A_DS_LSB +: 2] = st_r.clk_a_ds;
	end

	//------------------------------------------------------------
	// register writes and reads
	//------------------------------------------------------------
	// the reset register itself survives a full reset, else it could never be left
	always_comb begin
		st_nxt = st_r;
		// read answer is a one-cycle pulse, data zero when idle
		st_nxt.rvalid = reg_read;
		st_nxt.rdata = 8'h00;

		// soft reset bits are accepted at any time
		if (swrst_wr_hit) begin
			st_nxt.full_reset = reg_wdata[srdr_pkg::FULL_RST_BIT];
			st_nxt.part_reset = reg_wdata[srdr_pkg::PART_RST_BIT];
		end

		// settings: forced to defaults, or loaded from a write
		if (settings_held) begin
			// held at defaults; writes to settings are lost meanwhile
			st_nxt.ch7_slot_select = srdr_pkg::CH7_SLOT_RESET;
			st_nxt.ch7_drive_enable = srdr_pkg::CH7_DRV_RESET;
			st_nxt.serial_ds = srdr_pkg::DS_RESET;
			st_nxt.clk_b_ds = srdr_pkg::DS_RESET;
			st_nxt.clk_a_ds = srdr_pkg::DS_RESET;
		end else if (route_wr_hit) begin
			// reserved bits 3:1 are dropped here
			st_nxt.ch7_slot_select = reg_wdata[srdr_pkg::CH7_SLOT_LSB +: 4];
			st_nxt.ch7_drive_enable = reg_wdata[srdr_pkg::CH7_DRV_BIT];
		end else if (pad_wr_hit) begin
			// reserved bits 7:6 are dropped here
			st_nxt.serial_ds = reg_wdata[srdr_pkg::SERIAL_DS_LSB +: 2];
			st_nxt.clk_b_ds = reg_wdata[srdr_pkg::CLK_B_DS_LSB +: 2];
			st_nxt.clk_a_ds = reg_wdata[srdr_pkg::CLK_A_DS_LSB +: 2];
		end

		// reset register is write-only and reads zero, as do unmapped offsets
		// a read in the write cycle sees the old value, as st_r is used
		if (route_rd_hit) begin
			st_nxt.rdata = route_word;
		end else if (pad_rd_hit) begin
			st_nxt.rdata = pad_word;
		end
	end

	// hardware reset loads the documented defaults
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_r.ch7_slot_select <= srdr_pkg::CH7_SLOT_RESET;
			st_r.ch7_drive_enable <= srdr_pkg::CH7_DRV_RESET;
			st_r.serial_ds <= srdr_pkg::DS_RESET;
			st_r.clk_b_ds <= srdr_pkg::DS_RESET;
			st_r.clk_a_ds <= srdr_pkg::DS_RESET;
			st_r.full_reset <= srdr_pkg::SW_RESET_RESET[srdr_pkg::FULL_RST_BIT];
			st_r.part_reset <= srdr_pkg::SW_RESET_RESET[srdr_pkg::PART_RST_BIT];
			st_r.rdata <= 8'h00;
			st_r.rvalid <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	//------------------------------------------------------------
	// outputs and slot driver
	//------------------------------------------------------------
	// operating logic stops under either soft reset or hardware reset
	assign core_reset = reset || st_r.full_reset || st_r.part_reset;
	assign reg_rdata = st_r.rdata;
	assign reg_rvalid = st_r.rvalid;
	assign serial_out_drive_level = st_r.serial_ds;
	assign mic_clock_b_drive_level = st_r.clk_b_ds;
	assign mic_clock_a_drive_level = st_r.clk_a_ds;

	// routing into the pin driver
	assign slot_bus.slot_select = st_r.ch7_slot_select;
	assign slot_bus.drive_enable = st_r.ch7_drive_enable;
	assign slot_bus.run = !(st_r.full_reset || st_r.part_reset);
	assign slot_bus.slot_index = slot_index;
	assign slot_bus.slot_data = slot_data;

	srdr_slot_drive u_drive (
		.clk_sys(clk_sys),
		.reset(reset),
		.slot(slot_bus.drv),
		.serial_out_pin_o(serial_out_pin_o),
		.serial_out_pin_oe(serial_out_pin_oe)
	);
endmodule // srdr_regs

// >>> test/srdr_regs_checker.sv
`timescale 1ns/100ps
module srdr_regs_checker (
	// port signals watched
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic slot_data,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe,
	input wire logic [1:0] serial_out_drive_level,
	input wire logic [1:0] mic_clock_b_drive_level,
	input wire logic [1:0] mic_clock_a_drive_level,
	input wire logic core_reset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// read answer timing and idle level
	rvalid_timing_a: assert property (reg_read |=> reg_rvalid) else $error("no read answer");
	rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_read)) else $error("stray rvalid");
	rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00) else $error("rdata not 0");
	wo_reads_zero_a: assert property (reg_read && reg_addr == 8'h12 |=> reg_rdata == 8'h00)
		else $error("reset reg readable");
	// pin follows slot data only while running; drive levels take a write when not in reset
	pin_idle_low_a: assert property (!serial_out_pin_oe |-> !serial_out_pin_o) else $error("pin");
	pin_data_a: assert property (serial_out_pin_oe |-> serial_out_pin_o == $past(slot_data))
		else $error("pin data wrong");
	pin_stops_a: assert property (serial_out_pin_oe |-> !$past(core_reset)) else $error("oe");
	drive_write_a: assert property (reg_write && reg_addr == 8'h11 && !core_reset |=>
		{serial_out_drive_level, mic_clock_b_drive_level, mic_clock_a_drive_level}
		== $past(reg_wdata[5:0])) else $error("drive level not written");
	// main scenarios reached
	oe_seen_c: cover property (serial_out_pin_oe);
	ds_write_c: cover property (reg_write && reg_addr == 8'h11);
	soft_rst_c: cover property (core_reset && reg_rvalid);
endmodule // srdr_regs_checker

bind srdr_regs srdr_regs_checker i_chk (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write,
	.reg_read, .reg_rdata, .reg_rvalid, .slot_data, .serial_out_pin_o, .serial_out_pin_oe,
	.serial_out_drive_level, .mic_clock_b_drive_level, .mic_clock_a_drive_level, .core_reset);

// >>> test/srdr_ser_model.sv
`timescale 1ns/100ps
// serializer stand-in: walks all sixteen slots, data bit changes often
module srdr_ser_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// slot timing out
	output logic [3:0] slot_index,
	output logic slot_data
);
	initial slot_index = 4'h0;
	initial slot_data = 1'b0;
	// inputs move 1 ns after the edge, away from sampling
	always @(posedge clk_sys) begin
		#1 slot_index <= reset ? 4'h0 : slot_index + 4'h1;
		slot_data <= ^slot_index ^ slot_data;
	end
endmodule // srdr_ser_model

// >>> test/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic clk_sys = 0, reset = 1, reg_write = 0, reg_read = 0, reg_rvalid, slot_data, core_reset;
	logic serial_out_pin_o, serial_out_pin_oe;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	logic [3:0] slot_index;
	logic [1:0] serial_out_drive_level, mic_clock_b_drive_level, mic_clock_a_drive_level;
	logic [31:0] rng = 32'h7C7A99E5;
	int err_total = 0, num_checks = 0, n;
	srdr_regs i_dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.reg_rvalid, .slot_index, .slot_data, .serial_out_pin_o, .serial_out_pin_oe,
		.serial_out_drive_level, .mic_clock_b_drive_level, .mic_clock_a_drive_level, .core_reset);
	srdr_ser_model i_ser (.clk_sys, .reset, .slot_index, .slot_data);
	initial forever #2 clk_sys = ~clk_sys;
	// expectation helpers: reserved bits read back as zero
	function automatic logic [7:0] xs();
		rng ^= rng << 13; rng ^= rng >> 17; rng ^= rng << 5;
		return rng[7:0];
	endfunction
	function automatic logic [7:0] lv();
		return {2'h0, serial_out_drive_level, mic_clock_b_drive_level, mic_clock_a_drive_level};
	endfunction
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask
	// one strobe per call, an edge always passes before the next raise
	task automatic wr(logic [7:0] a, logic [7:0] w);
		@(posedge clk_sys); #1 reg_addr = a; reg_wdata = w; reg_write = 1;
		@(posedge clk_sys); #1 reg_write = 0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk_sys); #1 reg_addr = a; reg_read = 1;
		@(posedge clk_sys); #1 reg_read = 0;
		chk("rdata", e, reg_rdata);
		chk("rvalid", 8'h01, {7'h00, reg_rvalid});
	endtask
	// two full slot periods, so a routed slot shows twice
	task automatic pins(logic [7:0] e);
		n = 0;
		repeat (3) @(posedge clk_sys);
		repeat (32) begin
			@(posedge clk_sys); #1 if (serial_out_pin_oe === 1'b1) n++;
		end
		chk("oe count", e, n[7:0]);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#40000 err_total++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge clk_sys); #1 reset = 0;
		rd(8'h10, 8'h71);
		rd(8'h11, 8'h2A);
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h00);
		chk("levels", 8'h2A, lv());
		$display("reset values done");
		repeat (8) begin
			d = xs();
			wr(8'h10, d); rd(8'h10, d & 8'hF1);
			wr(8'h11, d); rd(8'h11, d & 8'h3F);
			chk("levels", d & 8'h3F, lv());
		end
		$display("random fields done");
		wr(8'h10, 8'hF1); pins(8'h02);
		wr(8'h10, 8'h50); pins(8'h00);
		wr(8'h10, 8'h51); wr(8'h12, 8'h01); pins(8'h00);
		chk("core reset", 8'h01, {7'h00, core_reset});
		rd(8'h10, 8'h51); wr(8'h12, 8'h00); pins(8'h02);
		$display("slot pin done");
		wr(8'h12, 8'h02); wr(8'h11, 8'h00); rd(8'h10, 8'h71); rd(8'h11, 8'h2A);
		wr(8'h12, 8'h00); wr(8'h11, 8'h15); rd(8'h11, 8'h15);
		$display("soft reset done");
		test_done();
	end
endmodule // testbench
